// [design/sct_pkg.sv]
// Constants, register map and carrier types of the synchronised system clock.
// Shared by the clock core and the minute-pulse front end; nothing is imported.
package sct_pkg;

  // Clock rate and the millisecond tick derived from it
  localparam int CLK_MHZ          = 250;
  localparam int TICK_MS          = 1;
  localparam int TICK_CYCLES_DFLT = TICK_MS * 1000 * CLK_MHZ;

  // Register byte offsets
  localparam logic [7:0] OFS_TRIM   = 8'h00;
  localparam logic [7:0] OFS_PSEL   = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_UTC    = 8'h0c;
  localparam logic [7:0] OFS_TIME   = 8'h10;
  localparam logic [7:0] OFS_SRC    = 8'h14;
  localparam logic [7:0] OFS_COUNT  = 8'h18;
  localparam logic [7:0] OFS_DEV    = 8'h1c;
  localparam logic [7:0] OFS_FILT   = 8'h20;

  // Field positions and widths
  localparam int TRIM_W          = 11;
  localparam int TRIM_SIGN_BIT   = 16;
  localparam int UTC_W           = 12;
  localparam int UTC_SUMMER_BIT  = 16;
  localparam int OFFSET_W        = 25;
  localparam int PSEL_W          = 4;

  // Reset values
  localparam logic signed [TRIM_W-1:0]   TRIM_RST   = 11'sh000;
  localparam logic                       DRIFT_RST  = 1'b0;
  localparam logic [PSEL_W-1:0]          PSEL_RST   = 4'h0;
  localparam logic signed [OFFSET_W-1:0] OFFSET_RST = 25'sh0000000;
  localparam logic signed [UTC_W-1:0]    UTC_RST    = 12'sh000;
  localparam logic [31:0]                TIME_RST   = 32'h0000_0000;

  // Drift sign encoding
  localparam logic DRIFT_LEAD = 1'b0;
  localparam logic DRIFT_LAG  = 1'b1;

  // Limits and timing, in milliseconds, seconds or hundredths of an hour
  localparam logic signed [TRIM_W-1:0]   TRIM_MAX       = 11'sd1000;
  localparam logic signed [UTC_W-1:0]    UTC_MAX        = 12'sd1500;
  localparam logic signed [OFFSET_W-1:0] OFFSET_MAX     = 25'sd10000000;
  localparam logic signed [31:0]         DEV_MAX        = 32'sd32767;
  localparam logic signed [15:0]         FILT_MAX       = 16'sd125;
  localparam int                         FILT_SHIFT     = 2;
  localparam logic signed [31:0]         STEP_LIMIT_MS  = 32'sd4000;
  localparam logic [16:0]                TIMEOUT_MS     = 17'd90000;
  localparam logic [31:0]                MS_PER_MIN     = 32'd60000;
  localparam logic [31:0]                MS_HALF_MIN    = 32'd30000;
  localparam logic [9:0]                 MS_PER_SEC     = 10'd1000;
  localparam logic signed [31:0]         MS_PER_CHOUR   = 32'sd36000;
  localparam logic [31:0]                SUMMER_MS      = 32'd3600000;
  localparam int                         MIN_PULSE_MS   = 50;

  // Reported time source
  typedef enum logic [3:0] {
    SRC_INTERNAL   = 4'h0,
    SRC_DIGITAL    = 4'h1,
    SRC_NTP        = 4'h2,
    SRC_SERIAL     = 4'h3,
    SRC_MODBUS     = 4'h4,
    SRC_MODBUS_TCP = 4'h5,
    SRC_PROFIBUS   = 4'h6,
    SRC_IEC101     = 4'h7,
    SRC_IEC103     = 4'h8,
    SRC_DNP3       = 4'h9,
    SRC_TIMECODE   = 4'ha
  } sct_source_e;

  // Decoded time message from a protocol or timecode receiver
  typedef struct packed {
    logic        valid;
    sct_source_e source;
    logic [31:0] msTime;
  } sct_event_s;

endpackage : sct_pkg

// [design/sct_pulse_edge.sv]
// Minute-pulse front end: synchronises every pulse input and flags a rising
// edge of the one chosen by the selector. Inputs are asynchronous pins.
`timescale 1ns/1ps
module sct_pulse_edge #(
  parameter int NUM_IN = 8
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Pulse pins and selection, 0 means none
  input  wire logic [NUM_IN-1:0]         pulseIn,
  input  wire logic [sct_pkg::PSEL_W-1:0] pulseSelect,
  // One-cycle rising edge of the selected input
  output logic                           pulseRise
);

  logic [NUM_IN-1:0] meta;
  logic [NUM_IN-1:0] stable;
  logic              selLevel;
  logic              prevLevel;
  logic              next_selLevel;
  logic              next_prevLevel;
  logic              next_pulseRise;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta[gi]   <= 1'b0;
          stable[gi] <= 1'b0;
        end
        else
        begin
          meta[gi]   <= pulseIn[gi];
          stable[gi] <= meta[gi];
        end
      end
    end
  endgenerate

  always_comb
  begin
    next_selLevel = 1'b0;
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (pulseSelect == sct_pkg::PSEL_W'(i + 1))
        next_selLevel = stable[i];
    end
    next_prevLevel = selLevel;
    // A change of selector can fake one edge; harmless, it is one sync event
    next_pulseRise = selLevel & ~prevLevel;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      selLevel  <= 1'b0;
      prevLevel <= 1'b0;
      pulseRise <= 1'b0;
    end
    else
    begin
      selLevel  <= next_selLevel;
      prevLevel <= next_prevLevel;
      pulseRise <= next_pulseRise;
    end
  end

endmodule : sct_pulse_edge

// [design/sct_clock_sync.sv]
// Millisecond system clock disciplined by minute pulses or decoded time messages,
// with deviation filtering, gradual correction, drift trim and its learning.
// Assumes an APB master on the same clock and decoders that deliver one-cycle events.
`timescale 1ns/1ps
module sct_clock_sync #(
  parameter int TICK_CYCLES  = sct_pkg::TICK_CYCLES_DFLT,
  parameter int NUM_PULSE_IN = 8
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Minute pulse pins
  input  wire logic [NUM_PULSE_IN-1:0] pulseIn,
  // Decoded message or timecode event
  input  wire sct_pkg::sct_event_s srcEvent,
  input  wire logic               timecodeFitted,
  // Clock state
  output logic [31:0]             sysTime,
  output logic                    msTick,
  output sct_pkg::sct_source_e    activeTimeSource
);

  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  generate
    if (TICK_CYCLES < 2 || NUM_PULSE_IN < 1 || NUM_PULSE_IN > 15)
    begin : g_bad
      $error("sct_clock_sync: unsupported parameter value");
    end
  endgenerate

  // Settings
  logic signed [sct_pkg::TRIM_W-1:0]   trimInterval;
  logic                                driftSign;
  logic [sct_pkg::PSEL_W-1:0]          pulseInputSelect;
  logic signed [sct_pkg::OFFSET_W-1:0] sourceOffsetComp;
  logic signed [sct_pkg::UTC_W-1:0]    utcOffsetHours;
  logic                                summerTimeEnable;
  logic signed [sct_pkg::TRIM_W-1:0]   next_trimInterval;
  logic                                next_driftSign;
  logic [sct_pkg::PSEL_W-1:0]          next_pulseInputSelect;
  logic signed [sct_pkg::OFFSET_W-1:0] next_sourceOffsetComp;
  logic signed [sct_pkg::UTC_W-1:0]    next_utcOffsetHours;
  logic                                next_summerTimeEnable;
  logic [31:0]                         next_prdata;

  // Core state
  logic [TW-1:0]        tickCnt;
  logic [9:0]           msInSec;
  logic [9:0]           secCnt;
  logic signed [15:0]   pend;
  logic [15:0]          syncEventCount;
  logic signed [15:0]   rawDeviation;
  logic signed [15:0]   filteredDeviation;
  logic [16:0]          quietMs;
  logic                 learnStrobe;
  logic                 learnLead;
  logic [TW-1:0]        next_tickCnt;
  logic [9:0]           next_msInSec;
  logic [9:0]           next_secCnt;
  logic signed [15:0]   next_pend;
  logic [15:0]          next_syncEventCount;
  logic signed [15:0]   next_rawDeviation;
  logic signed [15:0]   next_filteredDeviation;
  logic [16:0]          next_quietMs;
  logic                 next_learnStrobe;
  logic                 next_learnLead;
  logic [31:0]          next_sysTime;
  logic                 next_msTick;
  sct_pkg::sct_source_e next_activeTimeSource;

  logic        pulseRise;
  logic        apbWrite;
  logic        apbSetup;
  logic        addrHit;
  logic [9:0]  trimMag;

  assign apbWrite = psel & penable & pwrite;
  assign apbSetup = psel & ~penable;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addrHit;
  assign trimMag  = trimInterval[sct_pkg::TRIM_W-1] ? 10'(-trimInterval) : 10'(trimInterval);

  always_comb
  begin
    case (paddr)
      sct_pkg::OFS_TRIM, sct_pkg::OFS_PSEL, sct_pkg::OFS_OFFSET, sct_pkg::OFS_UTC, sct_pkg::OFS_TIME,
      sct_pkg::OFS_SRC, sct_pkg::OFS_COUNT, sct_pkg::OFS_DEV, sct_pkg::OFS_FILT: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  sct_pulse_edge #(
    .NUM_IN      (NUM_PULSE_IN)
  ) u_pulse (
    .clk         (clk),
    .rst_b       (rst_b),
    .pulseIn     (pulseIn),
    .pulseSelect (pulseInputSelect),
    .pulseRise   (pulseRise)
  );

  // Settings: software writes, learned trim, read data
  always_comb
  begin
    next_trimInterval     = trimInterval;
    next_driftSign        = driftSign;
    next_pulseInputSelect = pulseInputSelect;
    next_sourceOffsetComp = sourceOffsetComp;
    next_utcOffsetHours   = utcOffsetHours;
    next_summerTimeEnable = summerTimeEnable;
    next_prdata           = prdata;
    if (apbWrite && paddr == sct_pkg::OFS_TRIM)
    begin
      if ($signed(pwdata[sct_pkg::TRIM_W-1:0]) > sct_pkg::TRIM_MAX)
        next_trimInterval = sct_pkg::TRIM_MAX;
      else if ($signed(pwdata[sct_pkg::TRIM_W-1:0]) < -sct_pkg::TRIM_MAX)
        next_trimInterval = -sct_pkg::TRIM_MAX;
      else
        next_trimInterval = $signed(pwdata[sct_pkg::TRIM_W-1:0]);
      next_driftSign = pwdata[sct_pkg::TRIM_SIGN_BIT];
    end
    else if (learnStrobe)
    begin
      // Small steps per sync: convergence over days is intended
      if (trimMag == 10'd0)
      begin
        next_trimInterval = sct_pkg::TRIM_MAX;
        next_driftSign    = learnLead ? sct_pkg::DRIFT_LEAD : sct_pkg::DRIFT_LAG;
      end
      else if ((driftSign == sct_pkg::DRIFT_LEAD) == learnLead)
        next_trimInterval = (trimMag > 10'd1) ? sct_pkg::TRIM_W'(trimMag - 10'd1) : sct_pkg::TRIM_W'(trimMag);
      else if (trimMag >= 10'(sct_pkg::TRIM_MAX))
        next_driftSign = ~driftSign;
      else
        next_trimInterval = sct_pkg::TRIM_W'(trimMag + 10'd1);
    end
    if (apbWrite && paddr == sct_pkg::OFS_PSEL)
      next_pulseInputSelect = pwdata[sct_pkg::PSEL_W-1:0];
    if (apbWrite && paddr == sct_pkg::OFS_OFFSET)
    begin
      if ($signed(pwdata[sct_pkg::OFFSET_W-1:0]) > sct_pkg::OFFSET_MAX)
        next_sourceOffsetComp = sct_pkg::OFFSET_MAX;
      else if ($signed(pwdata[sct_pkg::OFFSET_W-1:0]) < -sct_pkg::OFFSET_MAX)
        next_sourceOffsetComp = -sct_pkg::OFFSET_MAX;
      else
        next_sourceOffsetComp = $signed(pwdata[sct_pkg::OFFSET_W-1:0]);
    end
    if (apbWrite && paddr == sct_pkg::OFS_UTC)
    begin
      if ($signed(pwdata[sct_pkg::UTC_W-1:0]) > sct_pkg::UTC_MAX)
        next_utcOffsetHours = sct_pkg::UTC_MAX;
      else if ($signed(pwdata[sct_pkg::UTC_W-1:0]) < -sct_pkg::UTC_MAX)
        next_utcOffsetHours = -sct_pkg::UTC_MAX;
      else
        next_utcOffsetHours = $signed(pwdata[sct_pkg::UTC_W-1:0]);
      next_summerTimeEnable = pwdata[sct_pkg::UTC_SUMMER_BIT];
    end
    if (apbSetup)
    begin
      case (paddr)
        sct_pkg::OFS_TRIM:   next_prdata = {15'h0000, driftSign, {(16 - sct_pkg::TRIM_W){trimInterval[10]}},
                                            trimInterval};
        sct_pkg::OFS_PSEL:   next_prdata = {28'h000_0000, pulseInputSelect};
        sct_pkg::OFS_OFFSET: next_prdata = {{(32 - sct_pkg::OFFSET_W){sourceOffsetComp[24]}}, sourceOffsetComp};
        sct_pkg::OFS_UTC:    next_prdata = {15'h0000, summerTimeEnable, {4{utcOffsetHours[11]}}, utcOffsetHours};
        sct_pkg::OFS_TIME:   next_prdata = sysTime;
        sct_pkg::OFS_SRC:    next_prdata = {28'h000_0000, activeTimeSource};
        sct_pkg::OFS_COUNT:  next_prdata = {16'h0000, syncEventCount};
        sct_pkg::OFS_DEV:    next_prdata = {{16{rawDeviation[15]}}, rawDeviation};
        sct_pkg::OFS_FILT:   next_prdata = {{16{filteredDeviation[15]}}, filteredDeviation};
        default:             next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trimInterval     <= sct_pkg::TRIM_RST;
      driftSign        <= sct_pkg::DRIFT_RST;
      pulseInputSelect <= sct_pkg::PSEL_RST;
      sourceOffsetComp <= sct_pkg::OFFSET_RST;
      utcOffsetHours   <= sct_pkg::UTC_RST;
      summerTimeEnable <= 1'b0;
      prdata           <= 32'h0000_0000;
    end
    else
    begin
      trimInterval     <= next_trimInterval;
      driftSign        <= next_driftSign;
      pulseInputSelect <= next_pulseInputSelect;
      sourceOffsetComp <= next_sourceOffsetComp;
      utcOffsetHours   <= next_utcOffsetHours;
      summerTimeEnable <= next_summerTimeEnable;
      prdata           <= next_prdata;
    end
  end

  // Core: tick, trim, sync events, deviation, filter, timeout
  logic               tickDone;
  logic               trimDue;
  logic               msgOk;
  logic               evValid;
  logic [31:0]        rem;
  logic [31:0]        refBase;
  logic [31:0]        refTime;
  logic signed [31:0] devFull;
  logic signed [31:0] devSat;
  logic signed [15:0] fNew;
  logic signed [15:0] pendWork;
  logic [1:0]         step;

  always_comb
  begin
    next_tickCnt           = tickCnt;
    next_msInSec           = msInSec;
    next_secCnt            = secCnt;
    next_syncEventCount    = syncEventCount;
    next_rawDeviation      = rawDeviation;
    next_filteredDeviation = filteredDeviation;
    next_quietMs           = quietMs;
    next_activeTimeSource  = activeTimeSource;
    next_learnStrobe       = 1'b0;
    next_learnLead         = learnLead;
    tickDone = (tickCnt == TICK_LAST);
    next_msTick = tickDone;
    next_tickCnt = tickDone ? '0 : tickCnt + TW'(1);
    trimDue = 1'b0;
    if (tickDone)
    begin
      next_msInSec = (msInSec == sct_pkg::MS_PER_SEC - 10'd1) ? 10'd0 : msInSec + 10'd1;
      if (msInSec == sct_pkg::MS_PER_SEC - 10'd1)
      begin
        next_secCnt = secCnt + 10'd1;
        if (trimMag != 10'd0 && secCnt + 10'd1 >= trimMag)
        begin
          next_secCnt = 10'd0;
          trimDue = 1'b1;
        end
      end
    end
    // Trim goes through the same slip path as sync corrections
    pendWork = pend;
    if (trimDue)
      pendWork = (driftSign == sct_pkg::DRIFT_LAG) ? pend + 16'sd1 : pend - 16'sd1;
    step = 2'd0;
    if (tickDone)
    begin
      if (pendWork < 0)
      begin
        step = 2'd0;
        pendWork = pendWork + 16'sd1;
      end
      else if (pendWork > 0)
      begin
        step = 2'd2;
        pendWork = pendWork - 16'sd1;
      end
      else
        step = 2'd1;
    end
    next_pend = pendWork;
    next_sysTime = sysTime + 32'(step);
    // Sync event and reference time
    msgOk = srcEvent.valid && srcEvent.source != sct_pkg::SRC_INTERNAL && srcEvent.source != sct_pkg::SRC_DIGITAL
            && srcEvent.source <= sct_pkg::SRC_TIMECODE
            && (srcEvent.source != sct_pkg::SRC_TIMECODE || timecodeFitted);
    evValid = pulseRise | msgOk;
    rem = sysTime % sct_pkg::MS_PER_MIN;
    if (pulseRise)
      refBase = (rem < sct_pkg::MS_HALF_MIN) ? sysTime - rem : sysTime + (sct_pkg::MS_PER_MIN - rem);
    else if (srcEvent.source == sct_pkg::SRC_NTP)
      refBase = srcEvent.msTime + 32'(32'(utcOffsetHours) * sct_pkg::MS_PER_CHOUR)
                + (summerTimeEnable ? sct_pkg::SUMMER_MS : 32'd0);
    else
      refBase = srcEvent.msTime;
    refTime = refBase + 32'(sourceOffsetComp);
    devFull = $signed(sysTime - refTime);
    if (devFull > sct_pkg::DEV_MAX)
      devSat = sct_pkg::DEV_MAX;
    else if (devFull < -sct_pkg::DEV_MAX)
      devSat = -sct_pkg::DEV_MAX;
    else
      devSat = devFull;
    fNew = filteredDeviation + 16'((devSat - 32'(filteredDeviation)) >>> sct_pkg::FILT_SHIFT);
    if (fNew > sct_pkg::FILT_MAX)
      fNew = sct_pkg::FILT_MAX;
    else if (fNew < -sct_pkg::FILT_MAX)
      fNew = -sct_pkg::FILT_MAX;
    if (evValid)
    begin
      next_syncEventCount   = syncEventCount + 16'd1;
      next_activeTimeSource = pulseRise ? sct_pkg::SRC_DIGITAL : srcEvent.source;
      next_quietMs          = 17'd0;
      next_rawDeviation     = 16'(devSat);
      if (devFull >= sct_pkg::STEP_LIMIT_MS || devFull <= -sct_pkg::STEP_LIMIT_MS)
      begin
        // Large error: jump; besides an OFS_TIME write, the only path allowed to move backwards
        next_sysTime = refTime;
        next_pend    = 16'sd0;
      end
      else
      begin
        // Positive deviation means leading: pay it back as skipped ticks
        next_filteredDeviation = fNew;
        next_pend              = pendWork - fNew;
        next_learnStrobe       = (fNew != 16'sd0) && (activeTimeSource != sct_pkg::SRC_INTERNAL);
        next_learnLead         = fNew > 16'sd0;
      end
    end
    else if (tickDone && activeTimeSource != sct_pkg::SRC_INTERNAL)
    begin
      next_quietMs = quietMs + 17'd1;
      if (quietMs + 17'd1 >= sct_pkg::TIMEOUT_MS)
        next_activeTimeSource = sct_pkg::SRC_INTERNAL;
    end
    if (apbWrite && paddr == sct_pkg::OFS_TIME)
    begin
      next_sysTime = pwdata;
      next_pend    = 16'sd0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tickCnt           <= '0;
      msInSec           <= 10'd0;
      secCnt            <= 10'd0;
      pend              <= 16'sd0;
      syncEventCount    <= 16'h0000;
      rawDeviation      <= 16'sh0000;
      filteredDeviation <= 16'sh0000;
      quietMs           <= 17'd0;
      learnStrobe       <= 1'b0;
      learnLead         <= 1'b0;
      sysTime           <= sct_pkg::TIME_RST;
      msTick            <= 1'b0;
      activeTimeSource  <= sct_pkg::SRC_INTERNAL;
    end
    else
    begin
      tickCnt           <= next_tickCnt;
      msInSec           <= next_msInSec;
      secCnt            <= next_secCnt;
      pend              <= next_pend;
      syncEventCount    <= next_syncEventCount;
      rawDeviation      <= next_rawDeviation;
      filteredDeviation <= next_filteredDeviation;
      quietMs           <= next_quietMs;
      learnStrobe       <= next_learnStrobe;
      learnLead         <= next_learnLead;
      sysTime           <= next_sysTime;
      msTick            <= next_msTick;
      activeTimeSource  <= next_activeTimeSource;
    end
  end

endmodule : sct_clock_sync

// [testbench/sct_clock_sync_properties.sv]
// Port checks of the synchronised clock core.
// Assumes no pulse edge together with a message.
`timescale 1ns/1ps
module sct_clock_sync_properties #(
  parameter int NUM_PULSE_IN = 8
) (
  // Core ports
  input wire logic                    clk,
  input wire logic                    rst_b,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [NUM_PULSE_IN-1:0] pulseIn,
  input wire sct_pkg::sct_event_s     srcEvent,
  input wire logic                    timecodeFitted,
  input wire logic [31:0]             sysTime,
  input wire logic                    msTick,
  input wire sct_pkg::sct_source_e    activeTimeSource
);
  // Cycles since the last event, pin change or time write
  logic [3:0]              quiet;
  logic [3:0]              next_quiet;
  logic [NUM_PULSE_IN-1:0] pinQ;
  logic                    timeWr;
  always_comb
  begin
    timeWr = psel && penable && pwrite && paddr == sct_pkg::OFS_TIME;
    next_quiet = (quiet == 4'hf) ? quiet : quiet + 4'h1;
    if (srcEvent.valid || timeWr || pulseIn != pinQ) next_quiet = 4'h0;
  end
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      quiet <= 4'h0;
      pinQ <= '0;
    end
    else
    begin
      quiet <= next_quiet;
      pinQ <= pulseIn;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_no_backstep: assert property (
    sysTime < $past(sysTime) |-> $past(sysTime) - sysTime >= 32'd4000 || $past(timeWr))
    else $error("clock stepped back by a small amount");
  chk_gentle_step: assert property (
    $changed(sysTime) && quiet > 4'h8 |-> (sysTime - $past(sysTime)) inside {32'd1, 32'd2})
    else $error("clock moved by more than one extra tick");
  chk_tick_single: assert property (
    msTick |=> !msTick [*8]) else $error("tick pulses too close");
  chk_src_legal: assert property (
    activeTimeSource <= sct_pkg::SRC_TIMECODE) else $error("source code out of range");
  chk_src_follow: assert property (
    srcEvent.valid && quiet > 4'h8 && srcEvent.source inside {[sct_pkg::SRC_NTP:sct_pkg::SRC_TIMECODE]}
    && (srcEvent.source != sct_pkg::SRC_TIMECODE || timecodeFitted)
    |=> activeTimeSource == $past(srcEvent.source)) else $error("source not reported");
  chk_tc_absent: assert property (
    srcEvent.valid && srcEvent.source == sct_pkg::SRC_TIMECODE && !timecodeFitted && quiet > 4'h8
    |=> $stable(activeTimeSource)) else $error("timecode taken without option");
  chk_src_cause: assert property (
    $changed(activeTimeSource) && activeTimeSource > sct_pkg::SRC_DIGITAL
    |-> $past(srcEvent.valid) && $past(srcEvent.source) == activeTimeSource)
    else $error("source changed without message");
  chk_slverr_map: assert property (
    psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > sct_pkg::OFS_FILT))
    else $error("error response wrong for address");
endmodule : sct_clock_sync_properties
bind sct_clock_sync sct_clock_sync_properties #(.NUM_PULSE_IN(NUM_PULSE_IN)) chk (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pulseIn(pulseIn), .srcEvent(srcEvent), .timecodeFitted(timecodeFitted),
  .sysTime(sysTime), .msTick(msTick), .activeTimeSource(activeTimeSource));

// [testbench/sct_time_source.sv]
// Far-side time source: minute pulse pins and decoded messages.
// Its tasks are entered right after a rising edge.
`timescale 1ns/1ps
module sct_time_source #(
  parameter int N  = 8,
  parameter int TK = 10
) (
  // Clock
  input  wire logic           clk,
  // Pins and messages
  output logic [N-1:0]        pulseIn,
  output sct_pkg::sct_event_s srcEvent
);
  initial pulseIn = '0;
  initial srcEvent = '0;
  task automatic pulse(input int k);
    pulseIn[k] <= 1'b1;
    repeat (50 * TK) @(posedge clk);
    pulseIn[k] <= 1'b0;
  endtask : pulse
  // Idle time field is inverted so a stale value is never mistaken for a fresh one
  task automatic send(input sct_pkg::sct_source_e s, input logic [31:0] t);
    srcEvent <= '{1'b1, s, t};
    @(posedge clk);
    srcEvent <= '{1'b0, s, ~t};
  endtask : send
endmodule : sct_time_source

// [testbench/sct_clock_sync_test.sv]
// Bench for the clock core: APB master, time source, read monitor.
// A 10-cycle tick keeps trim and sync spans short.
`timescale 1ns/1ps
module sct_clock_sync_test;
  localparam int TK = 10;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tcFit = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0, prdata, sysTime;
  logic                 pready, pslverr, msTick;
  logic [7:0]           pins;
  logic [15:0]          rnd = 16'd31894;
  sct_pkg::sct_event_s  ev;
  sct_pkg::sct_source_e src;
  logic [32:0]          loQ[$], hiQ[$];
  int                   n_errors = 0, compares = 0, nTick = 0, t, k;
  longint               t0;
  sct_time_source #(.N(8), .TK(TK)) far (.clk(clk), .pulseIn(pins), .srcEvent(ev));
  sct_clock_sync #(.TICK_CYCLES(TK), .NUM_PULSE_IN(8)) dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulseIn(pins), .srcEvent(ev), .timecodeFitted(tcFit), .sysTime(sysTime),
    .msTick(msTick), .activeTimeSource(src));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (msTick === 1'b1) nTick <= nTick + 1;
  always @(posedge clk)
    if (psel && penable && pready && !pwrite && loQ.size() > 0)
      checkSpan({pslverr, prdata}, loQ.pop_front(), hiQ.pop_front());
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic checkSpan(input logic [32:0] got, input logic [32:0] lo, input logic [32:0] hi);
    compares++;
    if (((got >= lo) && (got <= hi)) !== 1'b1)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h, want %h..%h", $time, got, lo, hi);
    end
  endtask : checkSpan
  task automatic chkTime(input int lo, input int hi);
    @(negedge clk);
    checkSpan({1'b0, sysTime}, 33'(lo), 33'(hi));
    @(posedge clk);
  endtask : chkTime
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] lo, input logic [32:0] hi);
    loQ.push_back(lo);
    hiQ.push_back(hi);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic summarize;
    if (loQ.size() != 0) n_errors++;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  initial
  begin
    #400000;
    n_errors++;
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 9; i++)
      if (i != 4) rd(8'(4 * i), 33'h0, 33'h0);
    rd(8'h24, 33'h1_0000_0000, 33'h1_0000_0000);
    apb(1'b1, sct_pkg::OFS_TRIM, 32'h0001_03ff);
    rd(sct_pkg::OFS_TRIM, 33'h1_03e8, 33'h1_03e8);
    apb(1'b1, sct_pkg::OFS_UTC, 32'h0001_07ff);
    rd(sct_pkg::OFS_UTC, 33'h1_05dc, 33'h1_05dc);
    apb(1'b1, sct_pkg::OFS_OFFSET, 32'h00ff_ffff);
    rd(sct_pkg::OFS_OFFSET, 33'h98_9680, 33'h98_9680);
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, sct_pkg::OFS_TRIM, 32'(1 + (s << 16)));
      apb(1'b1, sct_pkg::OFS_TIME, 32'h0);
      t = nTick;
      while (nTick - t < 2500) @(posedge clk);
      chkTime(nTick - t - 3 + 4 * s, nTick - t + 4 * s);
    end
    apb(1'b1, sct_pkg::OFS_TRIM, 32'h0);
    apb(1'b1, sct_pkg::OFS_OFFSET, 32'd2000);
    far.send(sct_pkg::SRC_NTP, 32'd1000000);
    t0 = $time;
    repeat (3) @(posedge clk);
    chkTime(58602000, 58602002);
    rd(sct_pkg::OFS_COUNT, 33'h1, 33'h1);
    rd(sct_pkg::OFS_DEV, 33'hffff_8001, 33'hffff_8001);
    far.send(sct_pkg::SRC_MODBUS, 32'(58599000 + ($time - t0) / 40));
    rd(sct_pkg::OFS_DEV, 33'd998, 33'd1002);
    rd(sct_pkg::OFS_FILT, 33'd125, 33'd125);
    rd(sct_pkg::OFS_TRIM, 33'h3e8, 33'h3e8);
    repeat (2000) @(posedge clk);
    chkTime(int'(58601873 + ($time - t0) / 40), int'(58601877 + ($time - t0) / 40));
    rnd = lfsr(rnd);
    k = int'(rnd[2:0]);
    apb(1'b1, sct_pkg::OFS_PSEL, 32'(k + 1));
    apb(1'b1, sct_pkg::OFS_TIME, 32'd320000);
    far.pulse(k);
    chkTime(302046, 302053);
    checkSpan({29'h0, src}, 33'h1, 33'h1);
    apb(1'b1, sct_pkg::OFS_PSEL, 32'h0);
    apb(1'b1, sct_pkg::OFS_TIME, 32'd320000);
    far.pulse(k);
    chkTime(320046, 320053);
    // Undefined source code must be refused, not reported
    far.send(sct_pkg::sct_source_e'(4'hf), 32'h0);
    repeat (10) @(posedge clk);
    far.send(sct_pkg::SRC_TIMECODE, 32'h0);
    tcFit <= 1'b1;
    repeat (10) @(posedge clk);
    far.send(sct_pkg::SRC_TIMECODE, 32'd5000000);
    repeat (3) @(posedge clk);
    rd(sct_pkg::OFS_COUNT, 33'h4, 33'h4);
    checkSpan({29'h0, src}, 33'ha, 33'ha);
    summarize();
  end
endmodule : sct_clock_sync_test
